/* src/dss_scanner.sv */
// Digit switch strobe scanner: rotates five strobes and captures BCD digits
//
// Functional notes
// - Scanning runs only when operation method parameter equals one.
// - Position is in command units; speed in units of 1000 per minute.
// - Position byte per slot: low nibble lower digit, high nibble next digit.
// - Speed byte per slot uses same weighting; speed spans six digits.
// - Inputs read as one when low; each nibble decodes as one BCD digit.
// - Five active-low strobes; exactly one selects the presented digit pair.
// - Strobes rotate slot0 through slot4 then back to slot0 continuously.
// - While a strobe is low, captured pairs go into matching digit positions.
// - Each strobe stays low one scan slot, default width 12 ms.
// - Slot width 12 to 2000 ms; sampling happens during the final 12 ms.
`timescale 1ns/10ps
`include "dss_defs.svh"
module dss_scanner #(
  parameter int unsigned CYC_PER_MS  = `DSS_CYC_PER_MS,
  parameter int unsigned READ_WIN_MS = `DSS_READ_WIN_MS
) (
  input  wire logic                       mclk_i,
  input  wire logic                       nrst_i,
  input  wire logic [7:0]                 operation_method_param_i,
  input  wire logic [10:0]                scan_slot_time_param_i,
  input  wire logic [7:0]                 pos_digit_n_i,
  input  wire logic [7:0]                 spd_digit_n_i,
  output logic      [4:0]                 strobe_n_o,
  output dss_pkg::dss_value_s             value_o,
  output logic                            value_valid_o,
  output logic                            bcd_error_o,
  output logic                            cycle_done_o
);
  localparam int unsigned SUB_W = 18;
  localparam int unsigned MS_W  = 11;

  // The sub-millisecond counter is SUB_W bits, so a faster clock would overflow it
  if (CYC_PER_MS < 1 || CYC_PER_MS > (1 << SUB_W)) begin : g_bad_cyc
    $error("dss_scanner: CYC_PER_MS out of range");
  end
  // A read window longer than the longest slot could never close
  if (READ_WIN_MS < 1 || READ_WIN_MS > `DSS_SLOT_MAX_MS) begin : g_bad_win
    $error("dss_scanner: READ_WIN_MS out of range");
  end

  logic [1:0] rst_sync_ff;
  logic       rst_n;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) rst_sync_ff <= 2'h0;
    else         rst_sync_ff <= {rst_sync_ff[0], 1'h1};
  end
  assign rst_n = rst_sync_ff[1];

  // Slot length clamped to legal range so a bad setting cannot stall the scan
  logic [10:0] slot_ms;
  always_comb begin
    slot_ms = scan_slot_time_param_i;
    if (slot_ms < 11'(`DSS_SLOT_MIN_MS)) slot_ms = 11'(`DSS_SLOT_MIN_MS);
    if (slot_ms > 11'(`DSS_SLOT_MAX_MS)) slot_ms = 11'(`DSS_SLOT_MAX_MS);
  end

  logic                       enable;
  logic [2:0]                 slot_ff;
  logic [2:0]                 nxt_slot;
  logic [SUB_W-1:0]           sub_ff;
  logic [SUB_W-1:0]           nxt_sub;
  logic [MS_W-1:0]            ms_ff;
  logic [MS_W-1:0]            nxt_ms;
  dss_pkg::dss_value_s        val_ff;
  dss_pkg::dss_value_s        nxt_val;
  logic                       valid_ff;
  logic                       nxt_valid;
  logic                       err_ff;
  logic                       nxt_err;
  logic                       done_ff;
  logic                       nxt_done;
  logic                       sampling;
  logic                       ms_tick;
  logic                       slot_end;
  logic                       scan_end;
  logic [7:0]                 pos_b;
  logic [7:0]                 spd_b;
  logic [`DSS_POS_DIGITS-1:0] pos_bad;
  logic [`DSS_SPD_DIGITS-1:0] spd_bad;

  assign enable   = (operation_method_param_i == 8'(`DSS_METHOD_SWITCH));
  assign pos_b    = ~pos_digit_n_i;
  assign spd_b    = ~spd_digit_n_i;
  assign ms_tick  = (sub_ff == SUB_W'(CYC_PER_MS - 1));
  // Last READ_WIN_MS milliseconds of the slot: external side must settle first
  assign sampling = enable && (32'(ms_ff) + 32'(READ_WIN_MS) >= 32'(slot_ms));
  assign slot_end = enable && ms_tick && (ms_ff + 11'h1 >= slot_ms);
  assign scan_end = slot_end && (slot_ff == 3'(`DSS_NUM_STROBES - 1));

  // Timer group: millisecond prescaler, slot length and strobe index
  always_comb begin
    nxt_slot = slot_ff;
    nxt_sub  = sub_ff;
    nxt_ms   = ms_ff;
    if (!enable) begin
      nxt_slot = 3'h0;
      nxt_sub  = 18'h0;
      nxt_ms   = 11'h0;
    end else begin
      nxt_sub = ms_tick ? 18'h0 : sub_ff + 18'h1;
      if (slot_end) begin
        nxt_ms = 11'h0;
        if (scan_end) begin
          nxt_slot = 3'h0;
        end else begin
          nxt_slot = slot_ff + 3'h1;
        end
      end else if (ms_tick) begin
        nxt_ms = ms_ff + 11'h1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      slot_ff <= 3'h0;
      sub_ff  <= 18'h0;
      ms_ff   <= 11'h0;
    end else begin
      slot_ff <= nxt_slot;
      sub_ff  <= nxt_sub;
      ms_ff   <= nxt_ms;
    end
  end

  // Capture group: last sample in the read window wins, so late settling is forgiven
  always_comb begin
    nxt_val = val_ff;
    if (sampling) begin
      for (int k = 0; k < 4; k++) begin
        if (slot_ff == 3'(k)) begin
          nxt_val.pos[2*k]   = pos_b[3:0];
          nxt_val.pos[2*k+1] = pos_b[7:4];
        end
      end
      for (int k = 0; k < 3; k++) begin
        if (slot_ff == 3'(k)) begin
          nxt_val.spd[2*k]   = spd_b[3:0];
          nxt_val.spd[2*k+1] = spd_b[7:4];
        end
      end
      if (slot_ff == 3'h4) begin
        nxt_val.sign_neg = pos_b[0];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      val_ff <= '0;
    end else begin
      val_ff <= nxt_val;
    end
  end

  // Digit checks: a nibble above nine is no BCD digit
  for (genvar i = 0; i < `DSS_POS_DIGITS; i++) begin : g_pos_chk
    assign pos_bad[i] = (val_ff.pos[i] > 4'h9);
  end
  for (genvar i = 0; i < `DSS_SPD_DIGITS; i++) begin : g_spd_chk
    assign spd_bad[i] = (val_ff.spd[i] > 4'h9);
  end

  // Status group: judged once per scan so a digit half way through its update is not flagged
  always_comb begin
    nxt_valid = valid_ff;
    nxt_err   = err_ff;
    nxt_done  = 1'h0;
    if (scan_end) begin
      nxt_valid = 1'h1;
      nxt_done  = 1'h1;
      nxt_err   = (|pos_bad) || (|spd_bad);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      valid_ff <= 1'h0;
      err_ff   <= 1'h0;
      done_ff  <= 1'h0;
    end else begin
      valid_ff <= nxt_valid;
      err_ff   <= nxt_err;
      done_ff  <= nxt_done;
    end
  end

  // Strobes all high while scanning is off so no switch bank is selected
  always_comb begin
    strobe_n_o = 5'h1F;
    if (enable) strobe_n_o[slot_ff] = 1'h0;
  end

  // Value is raw BCD; position in command units, speed in x1000 per minute
  assign value_o       = val_ff;
  assign value_valid_o = valid_ff;
  assign bcd_error_o   = err_ff;
  assign cycle_done_o  = done_ff;
endmodule

/* src/dss_defs.svh */
// Timing, mode and format constants for the digit switch strobe scanner
`ifndef DSS_DEFS_SVH
`define DSS_DEFS_SVH
`define DSS_CLK_MHZ        250
`define DSS_READ_WIN_MS    12
`define DSS_SLOT_MIN_MS    12
`define DSS_SLOT_MAX_MS    2000
`define DSS_SLOT_DEF_MS    12
`define DSS_CYC_PER_MS     (`DSS_CLK_MHZ * 1000)
`define DSS_READ_WIN_CYC   (`DSS_READ_WIN_MS * `DSS_CYC_PER_MS)
`define DSS_METHOD_SWITCH  1
`define DSS_NUM_STROBES    5
`define DSS_POS_DIGITS     8
`define DSS_SPD_DIGITS     6
`define DSS_SPD_UNIT       1000
`endif

/* src/dss_pkg.sv */
// Types for the digit switch strobe scanner
package dss_pkg;
  typedef logic [3:0] dss_bcd_t;
  typedef struct packed {
    logic     sign_neg;
    dss_bcd_t [7:0] pos;
    dss_bcd_t [5:0] spd;
  } dss_value_s;
endpackage

/* verif/dss_scanner_props.sv */
// Port checks for the strobe scanner
`timescale 1ns/10ps
module dss_scanner_props #(parameter int unsigned CYC_PER_MS = 1) (
  input wire logic                mclk_i,
  input wire logic                nrst_i,
  input wire logic [7:0]          operation_method_param_i,
  input wire logic [10:0]         scan_slot_time_param_i,
  input wire logic [7:0]          pos_digit_n_i,
  input wire logic [4:0]          strobe_n_o,
  input wire dss_pkg::dss_value_s value_o,
  input wire logic                cycle_done_o
);
  wire en = operation_method_param_i == 8'h01;
  // Slot length only known for a 12 ms setting
  wire fast = en && CYC_PER_MS == 1 && scan_slot_time_param_i == 11'h00C;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_low; (!strobe_n_o[0] || !en) [*8] ##1 (!strobe_n_o[0] || !en) [*4]; endsequence
  a_one_hot: assert property (en |-> $onehot(~strobe_n_o)) else $error("strobes");
  a_off_high: assert property (!en |-> &strobe_n_o) else $error("idle");
  a_rot_order: assert property (en && $past(en) && $changed(strobe_n_o) |->
    strobe_n_o == {$past(strobe_n_o[3:0]), $past(strobe_n_o[4])}) else $error("order");
  a_slot_len: assert property (fast && $fell(strobe_n_o[0]) |-> s_low ##1 strobe_n_o[0]) else $error("slot");
  a_done_end: assert property (en && $past(en) && $rose(strobe_n_o[4]) |-> cycle_done_o) else $error("done");
  a_off_hold: assert property (!en [*3] |-> $stable(value_o)) else $error("hold");
  a_pos_take: assert property (fast && !strobe_n_o[1] |=> value_o.pos[3:2] == ~$past(pos_digit_n_i))
    else $error("pos");
  a_sign_take: assert property (fast && !strobe_n_o[4] |=> value_o.sign_neg == !$past(pos_digit_n_i[0]))
    else $error("sign");
endmodule

/* verif/dss_switch_model.sv */
// Switch unit model answering the strobes
`timescale 1ns/10ps
module dss_switch_model (
  input  wire logic [4:0]          strobe_n_i,
  input  wire dss_pkg::dss_value_s set_i,
  output logic      [15:0]         data_n_o
);
  always_comb begin
    data_n_o = 16'hFFFF; // Open contacts read high
    for (int k = 0; k < 4; k++)
      if (!strobe_n_i[k])
        data_n_o = ~{set_i.pos[2*k +: 2], k < 3 ? set_i.spd[(2*k) % 6 +: 2] : 8'h00};
    if (!strobe_n_i[4]) data_n_o[8] = !set_i.sign_neg;
  end
endmodule

/* verif/dss_scanner_tb.sv */
// Bench for the strobe scanner
`timescale 1ns/10ps
module dss_scanner_tb;
  logic                mclk_i = 1'b0, nrst_i = 1'b0, err, valid, done;
  int                  n_done = 0;
  logic [7:0]          op = 8'h01;
  logic [15:0]         dat_n;
  logic [4:0]          stb_n;
  dss_pkg::dss_value_s set_v = '0, val;
  int                  err_total = 0, compares = 0;
  logic [57:0]         rows [3] = '{{2'h0, 32'h12345678, 24'h987654}, {2'h1, 32'h90000001, 24'h000305},
                                    {2'h2, 32'h0000000A, 24'h000000}};
  dss_scanner #(.CYC_PER_MS(1)) u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .operation_method_param_i(op),
    .scan_slot_time_param_i(11'h00C), .pos_digit_n_i(dat_n[15:8]), .spd_digit_n_i(dat_n[7:0]),
    .strobe_n_o(stb_n), .value_o(val), .value_valid_o(valid), .bcd_error_o(err), .cycle_done_o(done));
  dss_switch_model u_sw (.strobe_n_i(stb_n), .set_i(set_v), .data_n_o(dat_n));
  task automatic check(input logic [57:0] seen, input logic [57:0] exp, input string nm);
    compares++;
    if (seen !== exp) err_total++;
    if (seen !== exp) $display("wrong value %s expected %h seen %h", nm, exp, seen);
  endtask
  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial forever #2 mclk_i = ~mclk_i;
  initial begin
    repeat (20) @(negedge mclk_i);
    check(stb_n, 58'h1E, "stb");
    nrst_i = 1'b1;
    // A scan is 60 cycles; two of them leave no stale digit
    foreach (rows[i]) begin
      set_v = rows[i][56:0];
      repeat (125) @(negedge mclk_i);
      check({err, val}, rows[i], "val");
      check(valid, 58'h1, "valid");
      $display("row %0d ended", i);
    end
    op = 8'h00;
    set_v = '0;
    repeat (9) @(negedge mclk_i);
    check(val, rows[2][56:0], "held");
    $display("idle test ended");
    op = 8'h01;
    set_v = rows[0][56:0];
    nrst_i = 1'b0;
    @(negedge mclk_i);
    check(val, 58'h0, "rst val");
    check(stb_n, 58'h1E, "rst stb");
    check(valid, 58'h0, "rst valid");
    nrst_i = 1'b1;
    repeat (125) begin
      @(negedge mclk_i);
      n_done += done;
    end
    check(n_done, 58'h2, "done");
    check({err, val}, rows[0], "rescan");
    check(valid, 58'h1, "rescan valid");
    $display("reset test ended");
    wrap_up();
  end
endmodule
bind dss_scanner dss_scanner_props #(.CYC_PER_MS(CYC_PER_MS)) u_props (.*);
